// ---- rtl/tci_defs.svh ----
// Constants shared by both ends of the touch controller target port
`ifndef TCI_DEFS_SVH
`define TCI_DEFS_SVH

// Target address pairs: main pair and alternate pair
`define TCI_MAIN_WR   8'hba
`define TCI_MAIN_RD   8'hbb
`define TCI_ALT_WR    8'h28
`define TCI_ALT_RD    8'h29

// Bit positions within one nine-clock byte slot
`define TCI_BIT_LAST  4'h7
`define TCI_ACK_SLOT  4'h8
`define TCI_BIT_ONE   4'h1
`define TCI_BIT_ZERO  4'h0

// Register pointer and local storage
`define TCI_PTR_W     16
`define TCI_MEM_AW    8
`define TCI_MEM_DEPTH 256
`define TCI_PTR_STEP  16'h0001

// Link timing, in its own units
`define TCI_CLK_NS    10
`define TCI_RATE_BPS  400000
`define TCI_TLO_NS    1300
`define TCI_THI_NS    600

// Derived cycle counts at the system clock
`define TCI_LOW_CYC   ((`TCI_TLO_NS + `TCI_CLK_NS - 1) / `TCI_CLK_NS)
`define TCI_THI_CYC   ((`TCI_THI_NS + `TCI_CLK_NS - 1) / `TCI_CLK_NS)
`define TCI_BIT_CYC   ((1000000000 + `TCI_RATE_BPS * `TCI_CLK_NS - 1) / (`TCI_RATE_BPS * `TCI_CLK_NS))
`define TCI_LOW_HALF  (`TCI_LOW_CYC / 2)
`define TCI_SAMPLE    (`TCI_LOW_CYC + `TCI_THI_CYC)
`define TCI_BIT_END   (`TCI_BIT_CYC - 1)

`endif

// ---- rtl/tci_pkg.sv ----
// Types shared by both ends of the touch controller target port
package tci_pkg;

  typedef enum logic [2:0] {
    TCI_OP_START     = 3'h0,
    TCI_OP_WRITE     = 3'h1,
    TCI_OP_READ_ACK  = 3'h2,
    TCI_OP_READ_NACK = 3'h3,
    TCI_OP_STOP      = 3'h4
  } tci_op_t;

  typedef enum logic [1:0] {
    TCI_H_IDLE  = 2'h0,
    TCI_H_START = 2'h1,
    TCI_H_BIT   = 2'h2,
    TCI_H_STOP  = 2'h3
  } tci_hst_t;

  typedef enum logic [2:0] {
    TCI_D_IDLE  = 3'h0,
    TCI_D_ADDR  = 3'h1,
    TCI_D_REGH  = 3'h2,
    TCI_D_REGL  = 3'h3,
    TCI_D_WDATA = 3'h4,
    TCI_D_RDATA = 3'h5
  } tci_dst_t;

endpackage : tci_pkg

// ---- rtl/tci_if.sv ----
// Two-wire link between host and touch controller target
`timescale 1ns/1ps
interface tci_if;
  logic scl_o;
  logic scl_oe;
  logic sda_h_o;
  logic sda_h_oe;
  logic sda_d_o;
  logic sda_d_oe;
  logic scl;
  logic sda;

  // Open drain with pull-up: any enabled low driver wins
  assign scl = ~(scl_oe & ~scl_o);
  assign sda = ~((sda_h_oe & ~sda_h_o) | (sda_d_oe & ~sda_d_o));

  modport host (output scl_o, output scl_oe, output sda_h_o, output sda_h_oe,
                input scl, input sda);
  modport dev  (input scl, input sda, output sda_d_o, output sda_d_oe);
endinterface : tci_if

// ---- rtl/tci_host.sv ----
// Host end: byte-level master that clocks the two-wire link
`timescale 1ns/1ps
`include "tci_defs.svh"
module tci_host (
  // Link
  tci_if.host                link,
  // System
  input  wire logic          mclk_i,
  input  wire logic          rst_i,
  // Operation request
  input  wire logic          op_valid_i,
  input  wire tci_pkg::tci_op_t op_code_i,
  input  wire logic [7:0]    op_data_i,
  output logic               op_ready_o,
  // Operation result
  output logic               done_o,
  output logic [7:0]         rd_data_o,
  output logic               ack_o
);
  import tci_pkg::*;

  tci_hst_t    state, next_state;
  logic [7:0]  cnt, next_cnt;
  logic [3:0]  bitn, next_bitn;
  logic [8:0]  txv, next_txv;
  logic [8:0]  rxv, next_rxv;
  logic        scl_low, next_scl_low;
  logic        sda_low, next_sda_low;
  logic        ready, next_ready;
  logic        done, next_done;
  logic [7:0]  rdata, next_rdata;
  logic        ack, next_ack;
  logic        sda_s1;
  logic        sda_s2;

  // Pin sampling
  always_ff @(posedge mclk_i) begin
    sda_s1 <= link.sda;
    sda_s2 <= sda_s1;
  end

  always_comb begin
    next_state   = state;
    next_cnt     = cnt;
    next_bitn    = bitn;
    next_txv     = txv;
    next_rxv     = rxv;
    next_scl_low = scl_low;
    next_sda_low = sda_low;
    next_ready   = ready;
    next_done    = 1'b0;
    next_rdata   = rdata;
    next_ack     = ack;
    case (state)
      TCI_H_IDLE: begin
        if (op_valid_i && ready) begin // R01
          next_ready = 1'b0;
          next_cnt   = 8'h00;
          next_bitn  = `TCI_BIT_ZERO;
          case (op_code_i)
            TCI_OP_START:     next_state = TCI_H_START;
            TCI_OP_STOP:      next_state = TCI_H_STOP;
            TCI_OP_WRITE: begin
              next_txv   = {op_data_i, 1'b1};
              next_state = TCI_H_BIT;
            end
            TCI_OP_READ_ACK: begin
              next_txv   = {8'hff, 1'b0}; // R17
              next_state = TCI_H_BIT;
            end
            default: begin
              next_txv   = {8'hff, 1'b1}; // R18
              next_state = TCI_H_BIT;
            end
          endcase
        end
      end
      TCI_H_START: begin
        next_cnt = cnt + 8'h01;
        if (cnt == 8'h00) next_sda_low = 1'b0;
        if (cnt == 8'(`TCI_LOW_CYC)) next_scl_low = 1'b0;
        if (cnt == 8'(`TCI_SAMPLE)) next_sda_low = 1'b1; // R05
        // One extra count keeps the start hold time at full length
        if (cnt == 8'(`TCI_BIT_CYC)) begin
          next_scl_low = 1'b1;
          next_state   = TCI_H_IDLE;
          next_ready   = 1'b1;
          next_done    = 1'b1;
        end
      end
      TCI_H_BIT: begin
        next_cnt = cnt + 8'h01;
        // Data moves only while the clock is low
        if (cnt == 8'(`TCI_LOW_HALF)) next_sda_low = ~txv[8]; // R09
        if (cnt == 8'(`TCI_LOW_CYC)) next_scl_low = 1'b0; // R02
        if (cnt == 8'(`TCI_SAMPLE)) next_rxv = {rxv[7:0], sda_s2};
        if (cnt == 8'(`TCI_BIT_END)) begin
          next_scl_low = 1'b1;
          next_cnt     = 8'h00;
          next_txv     = {txv[7:0], 1'b1};
          next_bitn    = bitn + `TCI_BIT_ONE;
          if (bitn == `TCI_ACK_SLOT) begin // R08
            next_state = TCI_H_IDLE;
            next_ready = 1'b1;
            next_done  = 1'b1;
            next_rdata = rxv[8:1];
            next_ack   = ~rxv[0];
          end
        end
      end
      TCI_H_STOP: begin
        next_cnt = cnt + 8'h01;
        if (cnt == 8'(`TCI_LOW_HALF)) next_sda_low = 1'b1;
        if (cnt == 8'(`TCI_LOW_CYC)) next_scl_low = 1'b0;
        if (cnt == 8'(`TCI_SAMPLE)) next_sda_low = 1'b0; // R10
        if (cnt == 8'(`TCI_BIT_END)) begin
          next_state = TCI_H_IDLE;
          next_ready = 1'b1;
          next_done  = 1'b1;
        end
      end
      default: next_state = TCI_H_IDLE;
    endcase
  end

  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      state   <= TCI_H_IDLE;
      cnt     <= 8'h00;
      bitn    <= `TCI_BIT_ZERO;
      txv     <= 9'h1ff;
      rxv     <= 9'h000;
      scl_low <= 1'b0;
      sda_low <= 1'b0;
      ready   <= 1'b1;
      done    <= 1'b0;
      rdata   <= 8'h00;
      ack     <= 1'b0;
    end else begin
      state   <= next_state;
      cnt     <= next_cnt;
      bitn    <= next_bitn;
      txv     <= next_txv;
      rxv     <= next_rxv;
      scl_low <= next_scl_low;
      sda_low <= next_sda_low;
      ready   <= next_ready;
      done    <= next_done;
      rdata   <= next_rdata;
      ack     <= next_ack;
    end
  end

  // Open drain: level is always low, enable pulls the wire
  assign link.scl_o    = 1'b0;
  assign link.sda_h_o  = 1'b0;
  assign link.scl_oe   = scl_low;
  assign link.sda_h_oe = sda_low;
  assign op_ready_o    = ready;
  assign done_o        = done;
  assign rd_data_o     = rdata;
  assign ack_o         = ack;

endmodule : tci_host

// ---- rtl/tci_target.sv ----
// Device end: register target clocked by the link clock
//
// Functional notes
// R01: Device is target only, host starts all
// R02: Host keeps link at most 400 kbps
// R03: Two address pairs, respond on one only
// R04: Host picks address pair at power-up
// R05: Start is SDA falling while SCL high
// R06: Matching address acknowledged low in ninth clock
// R07: Unmatched address: no acknowledge, go idle
// R08: Byte is eight bits plus acknowledge bit
// R09: SDA valid only while SCL high
// R10: Stop is SDA rising while SCL high
// R11: Write: address, 16-bit register pointer, data
// R12: Store byte at pointer, then step pointer
// R13: Burst write runs until stop
// R14: Read first loads pointer with write address
// R15: Repeated start, read address, then data out
// R16: Continuous read while host keeps acknowledging
// R17: Host acknowledges every byte but the last
// R18: On not-acknowledge release SDA, stop sending
// R19: Pointer steps after each byte sent
`timescale 1ns/1ps
`include "tci_defs.svh"
module tci_target (
  // Link
  tci_if.dev                 link,
  // System
  input  wire logic          mclk_i,
  input  wire logic          rst_i,
  // Address pair strap
  input  wire logic          addr_sel_i,
  // Register write report
  output logic               wr_valid_o,
  output logic [15:0]        wr_addr_o,
  output logic [7:0]         wr_data_o
);
  import tci_pkg::*;

  // System clock side
  logic        link_rst;
  logic        sel, next_sel;
  logic        addr_sel_s1;
  logic        addr_sel_s2;
  logic        w_s1;
  logic        w_s2;
  logic        w_s3;
  logic        wr_valid, next_wr_valid;
  logic [15:0] wr_addr, next_wr_addr;
  logic [7:0]  wr_data, next_wr_data;

  // Condition detectors, clocked by the data line
  logic        start_tgl, next_start_tgl;
  logic        stop_tgl, next_stop_tgl;

  // Link clock side
  tci_dst_t    st, next_st;
  logic [3:0]  bcnt, next_bcnt;
  logic [7:0]  rsh, next_rsh;
  logic [7:0]  txsh, next_txsh;
  logic [15:0] ptr, next_ptr;
  logic        ack_pend, next_ack_pend;
  logic        start_seen, next_start_seen;
  logic        stop_seen, next_stop_seen;
  logic        sel_s1;
  logic        sel_s2;
  logic        wr_tgl, next_wr_tgl;
  logic [15:0] wr_addr_q, next_wr_addr_q;
  logic [7:0]  wr_data_q, next_wr_data_q;
  logic [7:0]  mem [`TCI_MEM_DEPTH];
  logic        mem_we;
  logic [7:0]  byte_in;
  logic [7:0]  addr_wr;
  logic [7:0]  addr_rd;
  logic        drive_low;
  logic        sda_oe_q;

  // Strap is a pin: synced first, so reset must outlast the two flops
  always_comb begin
    next_sel      = rst_i ? addr_sel_s2 : sel; // R04
    next_wr_valid = w_s2 ^ w_s3;
    next_wr_addr  = (w_s2 ^ w_s3) ? wr_addr_q : wr_addr;
    next_wr_data  = (w_s2 ^ w_s3) ? wr_data_q : wr_data;
  end

  // Address and data stay put for a whole byte, far longer than the sync
  always_ff @(posedge mclk_i) begin
    link_rst    <= rst_i;
    addr_sel_s1 <= addr_sel_i;
    addr_sel_s2 <= addr_sel_s1;
    sel         <= next_sel;
    w_s1     <= wr_tgl;
    w_s2     <= w_s1;
    if (rst_i) begin
      w_s3     <= 1'b0;
      wr_valid <= 1'b0;
      wr_addr  <= 16'h0000;
      wr_data  <= 8'h00;
    end else begin
      w_s3     <= w_s2;
      wr_valid <= next_wr_valid;
      wr_addr  <= next_wr_addr;
      wr_data  <= next_wr_data;
    end
  end

  always_comb begin
    next_start_tgl = link.scl ? ~start_tgl : start_tgl; // R05
    next_stop_tgl  = link.scl ? ~stop_tgl : stop_tgl; // R10
  end

  // The clock is idle high between frames, so edges of the data line
  // mark the conditions; the protocol keeps them stable long before use
  always_ff @(negedge link.sda or posedge link_rst) begin
    if (link_rst) start_tgl <= 1'b0;
    else start_tgl <= next_start_tgl;
  end

  always_ff @(posedge link.sda or posedge link_rst) begin
    if (link_rst) stop_tgl <= 1'b0;
    else stop_tgl <= next_stop_tgl;
  end

  assign addr_wr = sel_s2 ? `TCI_ALT_WR : `TCI_MAIN_WR; // R03
  assign addr_rd = sel_s2 ? `TCI_ALT_RD : `TCI_MAIN_RD; // R03
  // Sampled on the rising clock edge only
  assign byte_in = {rsh[6:0], link.sda}; // R09

  always_comb begin
    next_st         = st;
    next_bcnt       = bcnt;
    next_rsh        = rsh;
    next_txsh       = txsh;
    next_ptr        = ptr;
    next_ack_pend   = ack_pend;
    next_start_seen = start_seen;
    next_stop_seen  = stop_seen;
    next_wr_tgl     = wr_tgl;
    next_wr_addr_q  = wr_addr_q;
    next_wr_data_q  = wr_data_q;
    mem_we          = 1'b0;
    if (start_tgl != start_seen) begin // R05
      next_start_seen = start_tgl;
      next_stop_seen  = stop_tgl;
      next_st         = TCI_D_ADDR;
      next_bcnt       = `TCI_BIT_ONE;
      next_rsh        = byte_in;
      next_ack_pend   = 1'b0;
    end else if (stop_tgl != stop_seen) begin // R10 R13
      next_stop_seen = stop_tgl;
      next_st        = TCI_D_IDLE;
      next_bcnt      = `TCI_BIT_ZERO;
      next_ack_pend  = 1'b0;
    end else begin
      case (st)
        TCI_D_IDLE: next_bcnt = `TCI_BIT_ZERO;
        TCI_D_RDATA: begin
          if (bcnt == `TCI_ACK_SLOT) begin // R08
            next_bcnt     = `TCI_BIT_ZERO;
            next_ack_pend = 1'b0;
            if (ack_pend) begin
              next_st = TCI_D_RDATA;
            end else if (link.sda) begin
              next_st = TCI_D_IDLE; // R18
            end else begin
              next_txsh = mem[ptr[`TCI_MEM_AW-1:0]]; // R16
              next_ptr  = ptr + `TCI_PTR_STEP; // R19
            end
          end else begin
            next_txsh = {txsh[6:0], 1'b1};
            next_bcnt = bcnt + `TCI_BIT_ONE;
          end
        end
        default: begin
          if (bcnt == `TCI_ACK_SLOT) begin // R08
            next_bcnt     = `TCI_BIT_ZERO;
            next_ack_pend = 1'b0;
          end else begin
            next_rsh  = byte_in;
            next_bcnt = bcnt + `TCI_BIT_ONE;
            if (bcnt == `TCI_BIT_LAST) begin
              next_ack_pend = 1'b1;
              case (st)
                TCI_D_ADDR: begin
                  if (byte_in == addr_wr) begin // R06 R11 R14
                    next_st = TCI_D_REGH;
                  end else if (byte_in == addr_rd) begin // R06 R15
                    next_st   = TCI_D_RDATA;
                    next_txsh = mem[ptr[`TCI_MEM_AW-1:0]];
                    next_ptr  = ptr + `TCI_PTR_STEP; // R19
                  end else begin
                    next_st       = TCI_D_IDLE; // R07
                    next_ack_pend = 1'b0;
                  end
                end
                TCI_D_REGH: begin
                  next_ptr = {byte_in, ptr[7:0]};
                  next_st  = TCI_D_REGL;
                end
                TCI_D_REGL: begin
                  next_ptr = {ptr[15:8], byte_in};
                  next_st  = TCI_D_WDATA;
                end
                default: begin
                  mem_we         = 1'b1; // R12
                  next_ptr       = ptr + `TCI_PTR_STEP; // R12
                  next_wr_tgl    = ~wr_tgl;
                  next_wr_addr_q = ptr;
                  next_wr_data_q = byte_in;
                end
              endcase
            end
          end
        end
      endcase
    end
  end

  always_ff @(posedge link.scl or posedge link_rst) begin
    if (link_rst) begin
      st         <= TCI_D_IDLE;
      bcnt       <= `TCI_BIT_ZERO;
      rsh        <= 8'h00;
      txsh       <= 8'hff;
      ptr        <= 16'h0000;
      ack_pend   <= 1'b0;
      start_seen <= 1'b0;
      stop_seen  <= 1'b0;
      sel_s1     <= 1'b0;
      sel_s2     <= 1'b0;
      wr_tgl     <= 1'b0;
      wr_addr_q  <= 16'h0000;
      wr_data_q  <= 8'h00;
    end else begin
      st         <= next_st;
      bcnt       <= next_bcnt;
      rsh        <= next_rsh;
      txsh       <= next_txsh;
      ptr        <= next_ptr;
      ack_pend   <= next_ack_pend;
      start_seen <= next_start_seen;
      stop_seen  <= next_stop_seen;
      sel_s1     <= sel;
      sel_s2     <= sel_s1;
      wr_tgl     <= next_wr_tgl;
      wr_addr_q  <= next_wr_addr_q;
      wr_data_q  <= next_wr_data_q;
    end
  end

  // No reset on storage; contents are defined only after a write
  always_ff @(posedge link.scl) begin
    if (mem_we) mem[ptr[`TCI_MEM_AW-1:0]] <= byte_in;
  end

  // Data line only ever pulled low, changed on the falling clock edge
  assign drive_low = ack_pend // R06
                   | ((st == TCI_D_RDATA) && (bcnt != `TCI_ACK_SLOT) && !txsh[7]); // R15 R18

  always_ff @(negedge link.scl or posedge link_rst) begin
    if (link_rst) sda_oe_q <= 1'b0;
    else sda_oe_q <= drive_low; // R09
  end

  assign link.sda_d_o  = 1'b0;
  assign link.sda_d_oe = sda_oe_q;
  assign wr_valid_o    = wr_valid;
  assign wr_addr_o     = wr_addr;
  assign wr_data_o     = wr_data;

endmodule : tci_target

// ---- verif/tci_checker.sv ----
// Link checker for the touch controller target port
`timescale 1ns/1ps
`include "tci_defs.svh"
module tci_checker (
  // System
  input wire logic mclk_i,
  input wire logic rst_i,
  input wire logic addr_sel_i,
  // Link
  input wire logic scl_o,
  input wire logic scl_oe,
  input wire logic sda_h_o,
  input wire logic sda_h_oe,
  input wire logic sda_d_o,
  input wire logic sda_d_oe,
  input wire logic scl,
  input wire logic sda
);
  localparam int TLO = `TCI_LOW_CYC;
  localparam int THI = `TCI_THI_CYC;

  logic       scl_q;
  logic       sda_q;
  logic       act;
  logic       quiet;
  logic       nomatch;
  logic       nacked;
  logic       rd;
  logic [3:0] bit_n;
  logic [1:0] byte_n;
  logic [7:0] sh;
  logic [7:0] cnt;
  wire  [7:0] own   = addr_sel_i ? `TCI_ALT_WR : `TCI_MAIN_WR;
  wire        start = scl & scl_q & sda_q & ~sda;
  wire        stop  = scl & scl_q & ~sda_q & sda;
  wire        slot9 = act & scl & ~scl_q & (bit_n == 4'h8);
  wire        hit   = (sh[7:1] == own[7:1]);
  wire        first = (byte_n == 2'h0);

  // Host drives scl from a flop, so oversampling at mclk sees every level
  always_ff @(posedge mclk_i) begin
    scl_q <= scl;
    sda_q <= sda;
    if (rst_i) begin
      act     <= 1'b0;
      quiet   <= 1'b1;
      nomatch <= 1'b0;
      nacked  <= 1'b0;
      rd      <= 1'b0;
      bit_n   <= 4'h0;
      byte_n  <= 2'h0;
      cnt     <= 8'h00;
    end else begin
      cnt <= (scl != scl_q) ? 8'h01 : cnt + {7'h00, cnt != 8'hff};
      if (start) begin
        act     <= 1'b1;
        quiet   <= 1'b0;
        nomatch <= 1'b0;
        nacked  <= 1'b0;
        bit_n   <= 4'h0;
        byte_n  <= 2'h0;
      end else if (stop) begin
        act   <= 1'b0;
        quiet <= 1'b1;
      end else if (act && scl && !scl_q) begin
        if (bit_n != 4'h8) sh <= {sh[6:0], sda};
        bit_n <= (bit_n == 4'h8) ? 4'h0 : bit_n + 4'h1;
        if (slot9 && first) begin
          rd      <= sh[0];
          nomatch <= !hit;
        end
        if (slot9 && !first && rd && sda) nacked <= 1'b1;
        if (slot9 && byte_n != 2'h3) byte_n <= byte_n + 2'h1;
      end
    end
  end

  default clocking cb @(posedge mclk_i);
  endclocking
  default disable iff (rst_i);

  property p_dev_hold_hi; scl && $past(scl) |-> $stable(sda_d_oe); endproperty
  a_dev_hold_hi: assert property (p_dev_hold_hi) else $error("device sda moved, scl high");
  property p_addr_ack; slot9 && first && hit |-> sda_d_oe && !sda; endproperty
  a_addr_ack: assert property (p_addr_ack) else $error("own address not acknowledged");
  property p_addr_nack; slot9 && first && !hit |-> !sda_d_oe; endproperty
  a_addr_nack: assert property (p_addr_nack) else $error("foreign address acknowledged");
  property p_wr_ack; slot9 && !first && !rd && !nomatch |-> sda_d_oe; endproperty
  a_wr_ack: assert property (p_wr_ack) else $error("written byte not acknowledged");
  property p_rd_slot; slot9 && !first && rd |-> !sda_d_oe; endproperty
  a_rd_slot: assert property (p_rd_slot) else $error("device drove host ack slot");
  property p_open_drain; !scl_o && !sda_h_o && !sda_d_o; endproperty
  a_open_drain: assert property (p_open_drain) else $error("link driven high, not released");
  property p_idle; quiet |-> !sda_d_oe; endproperty
  a_idle: assert property (p_idle) else $error("device drove sda outside a frame");
  property p_nomatch; nomatch |-> !sda_d_oe [*2]; endproperty
  a_nomatch: assert property (p_nomatch) else $error("device active after foreign address");
  property p_nack; nacked |-> !sda_d_oe; endproperty
  a_nack: assert property (p_nack) else $error("device sent after host nack");
  property p_scl_low; $rose(scl) && act |-> cnt >= 8'(TLO); endproperty
  a_scl_low: assert property (p_scl_low) else $error("scl low phase too short");
  property p_scl_high; $fell(scl) && act |-> cnt >= 8'(THI); endproperty
  a_scl_high: assert property (p_scl_high) else $error("scl high phase too short");

  c_addr_ack: cover property (slot9 && first && hit);
  c_nack: cover property ($rose(nacked));
  c_nomatch: cover property ($rose(nomatch));
endmodule : tci_checker

// ---- verif/tb_touch_ctrl_i2c_target_port.sv ----
// Self-checking bench: host end talks to target end across the link
`timescale 1ns/1ps
`include "tci_defs.svh"
module tb_touch_ctrl_i2c_target_port;
  import tci_pkg::*;
  logic        mclk_i;
  logic        rst_i;
  logic        op_valid;
  tci_op_t     op_code;
  logic [7:0]  op_data;
  logic        op_ready;
  logic        done;
  logic        ack;
  logic [7:0]  rd_data;
  logic        addr_sel;
  logic        wr_valid;
  logic [15:0] wr_addr;
  logic [7:0]  wr_data;
  logic [7:0]  exp_mem [0:255];
  logic [15:0] wq_a [$];
  logic [7:0]  wq_d [$];
  int          bad_count;
  int          tests_run;

  tci_if link_if ();
  tci_host tci_host_i (.link(link_if), .mclk_i(mclk_i), .rst_i(rst_i), .op_valid_i(op_valid),
    .op_code_i(op_code), .op_data_i(op_data), .op_ready_o(op_ready), .done_o(done),
    .rd_data_o(rd_data), .ack_o(ack));
  tci_target tci_target_i (.link(link_if), .mclk_i(mclk_i), .rst_i(rst_i),
    .addr_sel_i(addr_sel), .wr_valid_o(wr_valid), .wr_addr_o(wr_addr), .wr_data_o(wr_data));
  tci_checker tci_checker_i (.mclk_i(mclk_i), .rst_i(rst_i), .addr_sel_i(addr_sel),
    .scl_o(link_if.scl_o), .scl_oe(link_if.scl_oe), .sda_h_o(link_if.sda_h_o),
    .sda_h_oe(link_if.sda_h_oe), .sda_d_o(link_if.sda_d_o), .sda_d_oe(link_if.sda_d_oe),
    .scl(link_if.scl), .sda(link_if.sda));

  always #5 mclk_i = ~mclk_i;

  // Sampled mid-cycle so the pulse is settled
  always @(negedge mclk_i) begin
    if (wr_valid === 1'b1) begin
      wq_a.push_back(wr_addr);
      wq_d.push_back(wr_data);
    end
  end

  task automatic summarize();
    $display("comparisons %0d mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : summarize

  task automatic chk_word(input string what, input logic [15:0] exp, input logic [15:0] got);
    tests_run++;
    if (got !== exp) begin
      bad_count++;
      $display("unexpected %s: expected %h seen %h", what, exp, got);
    end
  endtask : chk_word

  task automatic chk_bit(input string what, input logic exp, input logic got);
    tests_run++;
    if (got !== exp) begin
      bad_count++;
      $display("unexpected %s: expected %b seen %b", what, exp, got);
    end
  endtask : chk_bit

  task automatic hang(input string what);
    bad_count++;
    $display("unexpected %s: expected handshake seen timeout", what);
    summarize();
  endtask : hang

  // Request held until taken, then wait for the done pulse
  task automatic op(input tci_op_t c, input logic [7:0] d);
    int   n;
    logic rdy;
    n = 0;
    rdy = 1'b0;
    @(posedge mclk_i);
    op_valid <= 1'b1;
    op_code  <= c;
    op_data  <= d;
    while (!rdy) begin
      @(negedge mclk_i);
      rdy = (op_ready === 1'b1);
      @(posedge mclk_i);
      n++;
      if (n > 100) hang("op_ready");
    end
    op_valid <= 1'b0;
    n = 0;
    do begin
      @(negedge mclk_i);
      n++;
      if (n > 3000) hang("done");
    end while (done !== 1'b1);
  endtask : op

  task automatic wb(input logic [7:0] d, input logic e, input string what);
    op(TCI_OP_WRITE, d);
    chk_bit(what, e, ack);
  endtask : wb

  task automatic set_ptr(input logic [15:0] p, input logic [7:0] dev);
    op(TCI_OP_START, 8'h00);
    wb(dev, 1'b1, "address ack");
    wb(p[15:8], 1'b1, "pointer high ack");
    wb(p[7:0], 1'b1, "pointer low ack");
  endtask : set_ptr

  task automatic reg_write(input logic [15:0] p, input int n, input logic [7:0] d0,
                           input logic [7:0] dev);
    set_ptr(p, dev);
    for (int i = 0; i < n; i++) begin
      wb(d0 + 8'(i), 1'b1, "data ack");
      exp_mem[p[7:0] + 8'(i)] = d0 + 8'(i);
    end
    op(TCI_OP_STOP, 8'h00);
    chk_word("write count", 16'(n), 16'(wq_a.size()));
    for (int i = 0; i < n && wq_a.size() > 0; i++) begin
      chk_word("write address", p + 16'(i), wq_a.pop_front());
      chk_word("write data", {8'h00, d0 + 8'(i)}, {8'h00, wq_d.pop_front()});
    end
  endtask : reg_write

  task automatic reg_read(input logic [15:0] p, input int n, input logic [7:0] dev);
    set_ptr(p, dev);
    op(TCI_OP_START, 8'h00);
    wb(dev | 8'h01, 1'b1, "read address ack");
    for (int i = 0; i < n; i++) begin
      op((i == n - 1) ? TCI_OP_READ_NACK : TCI_OP_READ_ACK, 8'hff);
      chk_word("read data", {8'h00, exp_mem[p[7:0] + 8'(i)]}, {8'h00, rd_data});
      chk_bit("host ack", i != n - 1, ack);
    end
    op(TCI_OP_STOP, 8'h00);
  endtask : reg_read

  // Foreign address: no ack, frame ignored
  task automatic probe(input logic [7:0] a);
    op(TCI_OP_START, 8'h00);
    wb(a, 1'b0, "foreign address ack");
    op(TCI_OP_STOP, 8'h00);
  endtask : probe

  initial begin
    mclk_i = 1'b0;
    rst_i = 1'b1;
    op_valid = 1'b0;
    op_code = TCI_OP_START;
    op_data = 8'h00;
    addr_sel = 1'b0;
    bad_count = 0;
    tests_run = 0;
    repeat (4) @(posedge mclk_i);
    rst_i <= 1'b0;
    @(negedge mclk_i);
    chk_bit("idle scl", 1'b1, link_if.scl);
    chk_bit("idle sda", 1'b1, link_if.sda);
    probe(`TCI_ALT_WR);
    probe(`TCI_ALT_RD);
    $display("test main pair foreign done");
    reg_write(16'hfffe, 3, 8'h5a, `TCI_MAIN_WR);
    $display("test burst write with wrap done");
    reg_read(16'h00fe, 3, `TCI_MAIN_WR);
    $display("test burst read done");
    wb(`TCI_MAIN_WR, 1'b0, "address without start");
    op(TCI_OP_STOP, 8'h00);
    chk_word("writes without start", 16'h0000, 16'(wq_a.size()));
    $display("test no start done");
    // Strap only taken during reset, then needs link clocks to cross
    @(posedge mclk_i);
    rst_i <= 1'b1;
    addr_sel <= 1'b1;
    repeat (4) @(posedge mclk_i);
    rst_i <= 1'b0;
    probe(8'h00);
    probe(`TCI_MAIN_WR);
    probe(`TCI_MAIN_RD);
    reg_write(16'h0005, 1, 8'hc3, `TCI_ALT_WR);
    reg_read(16'h0005, 1, `TCI_ALT_WR);
    $display("test alternate pair done");
    summarize();
  end
endmodule : tb_touch_ctrl_i2c_target_port
